// >>> shared/disp_pkg.sv
//Contract
//- Cursor address is a low byte and a high byte selecting the RAM location.
//- Cursor address is a loadable, clearable 16-bit up-counter with ripple carry.
//- Loading low byte with bit 7 falling from one to zero increments high byte.
//- Code 0x0a selects low byte, 0x0b high byte; next data write loads it.
//- After code 0x0c each data write goes to RAM at cursor, then cursor advances.
//- Data read returns output register, then refills it from RAM and advances cursor.
//- Code 0x0e clears, 0x0f sets one bit at cursor, then cursor advances.
//- Bit position is written as position minus one in the three low data bits.
//- Read with read/write high and register select high returns busy on the top line.
//- Busy stands while executing; no instruction is accepted while busy.
//- An instruction register write leaves busy unchanged.
//- Busy is readable at any time without selecting it first.
//- In character mode the cursor shows at the cursor address location.
package disp_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int BUSY_BIT = 7;
  localparam int BITPOS_W = 3;
  localparam logic [7:0] CMD_CUR_LOW = 8'h0a;
  localparam logic [7:0] CMD_CUR_HIGH = 8'h0b;
  localparam logic [7:0] CMD_RAM_DATA = 8'h0c;
  localparam logic [7:0] CMD_BIT_CLR = 8'h0e;
  localparam logic [7:0] CMD_BIT_SET = 8'h0f;
  localparam logic [7:0] CODE_RST = 8'h00;
  localparam logic [7:0] OUT_RST = 8'h00;
  localparam logic [15:0] CURSOR_RST = 16'h0000;
  localparam logic [2:0] SYNC_RST = 3'h0;

  typedef enum logic [2:0] {
    OP_LOW,
    OP_HIGH,
    OP_WRITE,
    OP_FETCH,
    OP_CLR,
    OP_SET
  } op_kind_t;

  typedef struct packed {
    op_kind_t kind;
    logic [DATA_W-1:0] data;
  } op_t;

  typedef struct packed {
    logic e;
    logic rw;
    logic rs;
    logic [DATA_W-1:0] db;
  } pins_t;

  localparam int OP_W = $bits(op_t);
  localparam int PINS_W = $bits(pins_t);

  function automatic logic [15:0] cursor_inc(input logic [15:0] cur);
    cursor_inc = cur + 16'h0001;
  endfunction : cursor_inc

  function automatic logic [15:0] load_low(input logic [15:0] cur, input logic [7:0] low);
    logic [7:0] high;
    high = cur[15:8];
    if (cur[7] && !low[7]) begin
      high = high + 8'h01;
    end
    load_low = {high, low};
  endfunction : load_low

  function automatic logic [7:0] bit_mask(input logic [7:0] pos);
    bit_mask = 8'h01 << pos[BITPOS_W-1:0];
  endfunction : bit_mask
endpackage : disp_pkg

// >>> logic/op_fifo.sv
module op_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [WIDTH-1:0] o_rd_data
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] DEPTH_C = PW'(0) + (PW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [PW:0] cnt_reg, cnt_next;
  logic push, pop;

  assign o_wr_ready = (cnt_reg != DEPTH_C);
  assign o_rd_valid = (cnt_reg != '0);
  assign o_rd_data = mem[rp_reg];
  assign push = i_wr_valid && o_wr_ready;
  assign pop = o_rd_valid && i_rd_ready;

  always_comb begin
    wp_next = push ? wp_reg + PW'(1) : wp_reg;
    rp_next = pop ? rp_reg + PW'(1) : rp_reg;
    cnt_next = cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage has no reset; only pointers define what is valid
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem[wp_reg] <= i_wr_data;
    end
  end
endmodule : op_fifo

// >>> logic/display_ram_access_cmds.sv
module display_ram_access_cmds (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_bus_enable,
  input wire logic i_read_write,
  input wire logic i_register_select_line,
  input wire logic [7:0] i_parallel_data_lines,
  output logic [7:0] o_parallel_data_lines,
  output logic o_parallel_data_lines_oe_n,
  output logic [15:0] o_ram_addr,
  output logic o_ram_we,
  output logic o_ram_re,
  output logic [7:0] o_ram_wdata,
  input wire logic [7:0] i_ram_rdata,
  output logic [15:0] o_cursor_addr,
  output logic o_busy
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_MODIFY
  } exec_state_t;

  // Pin synchroniser: three stages, a bit changes once stages two and three agree
  logic [disp_pkg::PINS_W-1:0] s1_reg, s2_reg, s3_reg, q_reg, p_reg;
  logic [disp_pkg::PINS_W-1:0] s1_next, s2_next, s3_next, q_next, p_next;
  disp_pkg::pins_t q_pins, p_pins;

  always_comb begin
    s1_next = {i_bus_enable, i_read_write, i_register_select_line, i_parallel_data_lines};
    s2_next = s1_reg;
    s3_next = s2_reg;
    q_next = (s3_reg & ~(s2_reg ^ s3_reg)) | (q_reg & (s2_reg ^ s3_reg));
    p_next = q_reg;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q_reg <= '0;
      p_reg <= '0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      q_reg <= q_next;
      p_reg <= p_next;
    end
  end

  assign q_pins = disp_pkg::pins_t'(q_reg);
  assign p_pins = disp_pkg::pins_t'(p_reg);

  // An access completes on the falling edge of the qualified enable
  logic access_end, wr_instr, wr_data, rd_data;
  assign access_end = p_pins.e && !q_pins.e;
  assign wr_instr = access_end && !p_pins.rw && p_pins.rs;
  assign wr_data = access_end && !p_pins.rw && !p_pins.rs;
  assign rd_data = access_end && p_pins.rw && !p_pins.rs;

  // Instruction code register
  logic [7:0] code_reg, code_next;

  always_comb begin
    code_next = code_reg;
    if (wr_instr && !o_busy) begin
      code_next = p_pins.db;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      code_reg <= disp_pkg::CODE_RST;
    end else begin
      code_reg <= code_next;
    end
  end

  // Translate host data accesses into queued operations
  disp_pkg::op_t in_op, out_op;
  logic in_valid, in_ready, out_valid, out_ready;

  always_comb begin
    in_op.data = p_pins.db;
    in_op.kind = disp_pkg::OP_WRITE;
    in_valid = 1'b0;
    if (rd_data && code_reg == disp_pkg::CMD_RAM_DATA) begin
      in_op.kind = disp_pkg::OP_FETCH;
      in_valid = 1'b1;
    end else if (wr_data) begin
      in_valid = 1'b1;
      unique case (code_reg)
        disp_pkg::CMD_CUR_LOW: in_op.kind = disp_pkg::OP_LOW;
        disp_pkg::CMD_CUR_HIGH: in_op.kind = disp_pkg::OP_HIGH;
        disp_pkg::CMD_RAM_DATA: in_op.kind = disp_pkg::OP_WRITE;
        disp_pkg::CMD_BIT_CLR: in_op.kind = disp_pkg::OP_CLR;
        disp_pkg::CMD_BIT_SET: in_op.kind = disp_pkg::OP_SET;
        default: in_valid = 1'b0;
      endcase
    end
  end

  // A write that meets a full queue is lost; busy warns the host long before that
  op_fifo #(
    .WIDTH(disp_pkg::OP_W),
    .DEPTH(disp_pkg::FIFO_DEPTH)
  ) u_op_fifo (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_wr_valid(in_valid),
    .o_wr_ready(in_ready),
    .i_wr_data(in_op),
    .o_rd_valid(out_valid),
    .i_rd_ready(out_ready),
    .o_rd_data(out_op)
  );

  // Executor: cursor counter, output register and RAM port
  exec_state_t st_reg, st_next;
  logic [15:0] cur_reg, cur_next;
  logic [15:0] addr_reg, addr_next;
  logic [7:0] out_reg, out_next;
  logic [7:0] wdata_reg, wdata_next;
  logic [7:0] pos_reg, pos_next;
  logic set_reg, set_next;
  logic we_reg, we_next, re_reg, re_next;

  assign out_ready = (st_reg == ST_IDLE);

  always_comb begin
    st_next = st_reg;
    cur_next = cur_reg;
    addr_next = addr_reg;
    out_next = out_reg;
    wdata_next = wdata_reg;
    pos_next = pos_reg;
    set_next = set_reg;
    we_next = 1'b0;
    re_next = 1'b0;
    unique case (st_reg)
      ST_IDLE: begin
        if (out_valid) begin
          unique case (out_op.kind)
            disp_pkg::OP_LOW: begin
              cur_next = disp_pkg::load_low(cur_reg, out_op.data);
            end
            disp_pkg::OP_HIGH: begin
              cur_next = {out_op.data, cur_reg[7:0]};
            end
            disp_pkg::OP_WRITE: begin
              addr_next = cur_reg;
              wdata_next = out_op.data;
              we_next = 1'b1;
              cur_next = disp_pkg::cursor_inc(cur_reg);
            end
            disp_pkg::OP_FETCH: begin
              addr_next = cur_reg;
              re_next = 1'b1;
              cur_next = disp_pkg::cursor_inc(cur_reg);
              st_next = ST_FETCH;
            end
            disp_pkg::OP_CLR, disp_pkg::OP_SET: begin
              addr_next = cur_reg;
              re_next = 1'b1;
              pos_next = {5'h00, out_op.data[disp_pkg::BITPOS_W-1:0]};
              set_next = (out_op.kind == disp_pkg::OP_SET);
              st_next = ST_MODIFY;
            end
            default: begin
              st_next = ST_IDLE;
            end
          endcase
        end
      end
      ST_FETCH: begin
        // Refill happens after the old value went out, hence the dummy read
        if (!re_reg) begin
          out_next = i_ram_rdata;
          st_next = ST_IDLE;
        end
      end
      ST_MODIFY: begin
        if (!re_reg) begin
          if (set_reg) begin
            wdata_next = i_ram_rdata | disp_pkg::bit_mask(pos_reg);
          end else begin
            wdata_next = i_ram_rdata & ~disp_pkg::bit_mask(pos_reg);
          end
          we_next = 1'b1;
          cur_next = disp_pkg::cursor_inc(cur_reg);
          st_next = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      st_reg <= ST_IDLE;
      cur_reg <= disp_pkg::CURSOR_RST;
      addr_reg <= disp_pkg::CURSOR_RST;
      out_reg <= disp_pkg::OUT_RST;
      wdata_reg <= disp_pkg::OUT_RST;
      pos_reg <= disp_pkg::OUT_RST;
      set_reg <= 1'b0;
      we_reg <= 1'b0;
      re_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cur_reg <= cur_next;
      addr_reg <= addr_next;
      out_reg <= out_next;
      wdata_reg <= wdata_next;
      pos_reg <= pos_next;
      set_reg <= set_next;
      we_reg <= we_next;
      re_reg <= re_next;
    end
  end

  assign o_ram_addr = addr_reg;
  assign o_ram_we = we_reg;
  assign o_ram_re = re_reg;
  assign o_ram_wdata = wdata_reg;
  assign o_cursor_addr = cur_reg;

  // Busy and the host read port
  logic busy_reg, busy_next;
  logic [7:0] dout_reg, dout_next;
  logic oe_n_reg, oe_n_next;

  always_comb begin
    // Queue or executor work in flight, never the instruction write alone
    // The write pulse that ends a bit operation still counts as work in flight
    busy_next = out_valid || in_valid || (st_next != ST_IDLE) || !in_ready
      || we_next;
    oe_n_next = !(q_pins.e && q_pins.rw);
    if (q_pins.rs) begin
      dout_next = 8'h00;
      dout_next[disp_pkg::BUSY_BIT] = busy_reg;
    end else begin
      dout_next = out_reg;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      busy_reg <= 1'b0;
      dout_reg <= disp_pkg::OUT_RST;
      oe_n_reg <= 1'b1;
    end else begin
      busy_reg <= busy_next;
      dout_reg <= dout_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign o_busy = busy_reg;
  assign o_parallel_data_lines = dout_reg;
  assign o_parallel_data_lines_oe_n = oe_n_reg;
endmodule : display_ram_access_cmds

// >>> dv/display_ram_access_cmds_checker.sv
module display_ram_access_cmds_checker (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_bus_enable,
  input wire logic i_read_write,
  input wire logic i_register_select_line,
  input wire logic [7:0] i_parallel_data_lines,
  input wire logic [7:0] o_parallel_data_lines,
  input wire logic o_parallel_data_lines_oe_n,
  input wire logic [15:0] o_ram_addr,
  input wire logic o_ram_we,
  input wire logic o_ram_re,
  input wire logic [7:0] o_ram_wdata,
  input wire logic [7:0] i_ram_rdata,
  input wire logic [15:0] o_cursor_addr,
  input wire logic o_busy
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);
  chk_we_pulse: assert property (o_ram_we |=> !o_ram_we)
    else $error("RAM write strobe too long");
  chk_re_pulse: assert property (o_ram_re |=> !o_ram_re)
    else $error("RAM read strobe too long");
  chk_write_advance: assert property (o_ram_we |-> o_cursor_addr == o_ram_addr + 16'h0001)
    else $error("Cursor not one past write address");
  chk_busy_on_we: assert property (o_ram_we |-> o_busy)
    else $error("RAM write while not busy");
  chk_bitop_addr: assert property (o_ram_re ##2 o_ram_we |-> $stable(o_ram_addr))
    else $error("Bit operation moved its address");
  chk_idle_ram: assert property (!o_busy |-> !o_ram_we && !o_ram_re)
    else $error("RAM access while idle");
  chk_oe_release: assert property (!i_bus_enable [*8] |-> o_parallel_data_lines_oe_n)
    else $error("Data pins still driven after strobe");
  chk_cursor_hold: assert property (!o_busy && !$past(o_busy) |-> $stable(o_cursor_addr))
    else $error("Cursor moved while idle");
  cov_write: cover property (o_ram_we && !$past(o_ram_re, 2));
  cov_bitop: cover property (o_ram_re ##2 o_ram_we);
  cov_wrap: cover property (o_ram_we && o_ram_addr == 16'hffff);
endmodule : display_ram_access_cmds_checker

bind display_ram_access_cmds display_ram_access_cmds_checker i_checker (.*);

// >>> dv/disp_ram_model.sv
module disp_ram_model (
  input wire logic i_core_clk,
  input wire logic [15:0] i_addr,
  input wire logic i_we,
  input wire logic i_re,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:65535];
  logic [7:0] hold_q = 8'h00;
  logic hold_v = 1'b0;
  always @(posedge i_core_clk) begin
    if (i_we) mem[i_addr] <= i_wdata;
    hold_v <= i_re;
    if (i_re) hold_q <= mem[i_addr];
  end
  // Stale data is inverted so a late capture cannot match by chance
  assign o_rdata = i_re ? mem[i_addr] : (hold_v ? hold_q : ~hold_q);
endmodule : disp_ram_model

// >>> dv/display_ram_access_cmds_tb_top.sv
`define CHECK(a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module display_ram_access_cmds_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_core_clk = 1'b0, i_sys_rst = 1'b1, i_bus_enable = 1'b0, i_read_write = 1'b1;
  logic i_register_select_line = 1'b1, hdrv = 1'b0;
  logic [7:0] hdb = 8'h00, q, i_parallel_data_lines, o_parallel_data_lines;
  logic [7:0] i_ram_rdata, o_ram_wdata;
  logic o_parallel_data_lines_oe_n, o_ram_we, o_ram_re, o_busy;
  logic [15:0] o_ram_addr, o_cursor_addr;
  int tests_run = 0, mismatches = 0;
  // Undriven data pins float high as if pulled up
  assign i_parallel_data_lines = hdrv ? hdb :
    (o_parallel_data_lines_oe_n ? 8'hff : o_parallel_data_lines);
  display_ram_access_cmds i_display_ram_access_cmds (.*);
  disp_ram_model i_disp_ram_model (.i_core_clk(i_core_clk), .i_addr(o_ram_addr),
    .i_we(o_ram_we), .i_re(o_ram_re), .i_wdata(o_ram_wdata), .o_rdata(i_ram_rdata));
  initial begin
    forever #5 i_core_clk = ~i_core_clk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  // Pins pass a synchroniser, so every level is held well past its depth
  task automatic bus(input logic rw, input logic rs, input logic [7:0] d,
                     output logic [7:0] r);
    @(negedge i_core_clk);
    i_read_write = rw;
    i_register_select_line = rs;
    hdb = d;
    hdrv = !rw;
    repeat (6) @(negedge i_core_clk);
    i_bus_enable = 1'b1;
    repeat (10) @(negedge i_core_clk);
    r = i_parallel_data_lines;
    i_bus_enable = 1'b0;
    repeat (10) @(negedge i_core_clk);
    hdrv = 1'b0;
  endtask : bus
  task automatic poll();
    int n;
    n = 0;
    q = 8'h80;
    while (q[7] !== 1'b0 && n < 20) begin
      bus(1'b1, 1'b1, 8'h00, q);
      n++;
    end
    `CHECK(q, 8'h00)
    if (n == 20) summarize();
  endtask : poll
  task automatic wr(input logic rs, input logic [7:0] d);
    poll();
    bus(1'b0, rs, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] e);
    poll();
    bus(1'b1, 1'b0, 8'h00, q);
    `CHECK(q, e)
  endtask : rd
  task automatic setcur(input logic [15:0] a);
    wr(1'b1, disp_pkg::CMD_CUR_LOW);
    wr(1'b0, a[7:0]);
    wr(1'b1, disp_pkg::CMD_CUR_HIGH);
    wr(1'b0, a[15:8]);
  endtask : setcur
  task automatic chkcur(input logic [15:0] e);
    poll();
    `CHECK(o_cursor_addr, e)
  endtask : chkcur
  initial begin
    repeat (6) @(negedge i_core_clk);
    i_sys_rst = 1'b0;
    `CHECK({o_busy, o_parallel_data_lines_oe_n, o_cursor_addr}, 18'h10000)
    setcur(16'h1280);
    chkcur(16'h1280);
    wr(1'b1, disp_pkg::CMD_RAM_DATA);
    wr(1'b0, 8'ha5);
    wr(1'b0, 8'h3c);
    chkcur(16'h1282);
    wr(1'b1, disp_pkg::CMD_CUR_LOW);
    wr(1'b0, 8'h05);
    chkcur(16'h1305);
    wr(1'b1, disp_pkg::CMD_CUR_HIGH);
    wr(1'b0, 8'h12);
    chkcur(16'h1205);
    setcur(16'hffff);
    wr(1'b1, disp_pkg::CMD_RAM_DATA);
    wr(1'b0, 8'h77);
    chkcur(16'h0000);
    setcur(16'h1280);
    wr(1'b1, disp_pkg::CMD_BIT_CLR);
    wr(1'b0, 8'h07);
    wr(1'b1, disp_pkg::CMD_BIT_SET);
    wr(1'b0, 8'h01);
    chkcur(16'h1282);
    setcur(16'h1280);
    wr(1'b1, disp_pkg::CMD_RAM_DATA);
    poll();
    bus(1'b1, 1'b0, 8'h00, q);
    rd(8'h25);
    rd(8'h3e);
    chkcur(16'h1283);
    setcur(16'hffff);
    wr(1'b1, disp_pkg::CMD_RAM_DATA);
    poll();
    bus(1'b1, 1'b0, 8'h00, q);
    rd(8'h77);
    chkcur(16'h0001);
    summarize();
  end
endmodule : display_ram_access_cmds_tb_top
